/* File: rtl/lpc_fw_map.svh */
// constants of the firmware memory read target: field codes, size codes,
// field counts and address bit positions.
// assumes: included by the package and by the design files that decode fields.
`ifndef LPC_FW_MAP_SVH
`define LPC_FW_MAP_SVH

// start codes
`define LPC_START_READ 4'hD
`define LPC_START_WRITE 4'hE

// driven nibbles
`define LPC_TAR_NIBBLE 4'hF
`define LPC_SYNC_READY 4'h0
`define LPC_LAD_DRIVE 4'hF
`define LPC_LAD_RELEASE 4'h0

// address field
`define LPC_ADDR_NIBBLES 3'h7
`define LPC_ADDR_LAST 3'h1
`define LPC_ADDR_KEEP_MSB 23
`define LPC_DECODE_MSB 20
`define LPC_SPACE_BIT 22
`define LPC_ADDR_STEP 21'h000001

// transfer size codes
`define LPC_SIZE_1 4'h0
`define LPC_SIZE_2 4'h1
`define LPC_SIZE_4 4'h2
`define LPC_SIZE_16 4'h4
`define LPC_SIZE_128 4'h7

// burst arithmetic
`define LPC_NIBBLES_ONE_BYTE 9'h002
`define LPC_NIBBLE_ONE 9'h001
`define LPC_COUNT_STEP 8'h01

`endif

/* File: rtl/lpc_fw_pkg.sv */
// types and field helpers of the firmware memory read target.
// assumes: the map header sits beside it on the include path.
`include "lpc_fw_map.svh"

package lpc_fw_pkg;

  // ---------------------------------------------------------------
  // link phases and state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_IDLE,
    PH_START,
    PH_ADDR,
    PH_SIZE,
    PH_TAR0,
    PH_TAR1,
    PH_SYNC,
    PH_DATA,
    PH_TAR_END
  } link_phase_t;

  typedef struct packed {
    logic [3:0] value;
    logic [3:0] enable;
  } lad_drive_t;

  typedef struct packed {
    link_phase_t phase;
    logic [3:0] start_code;
    logic write_dir;
    logic [27:0] addr;
    logic [2:0] addr_left;
    logic [3:0] size_code;
    logic [7:0] nib_count;
    logic [7:0] nib_last;
    logic [3:0] hold_hi;
    logic [20:0] byte_addr;
    logic flash_space;
    lad_drive_t lad;
    logic frame_idle;
    logic write_toggle;
    logic [27:0] write_addr;
  } link_state_t;

  typedef struct packed {
    logic standby;
    logic cmd_pending;
    logic cmd_start;
    logic write_cycle;
    logic [27:0] cmd_addr;
  } sys_state_t;

  // ---------------------------------------------------------------
  // field helpers
  // ---------------------------------------------------------------
  function automatic logic size_valid(input logic [3:0] code,
                                      input logic is_write);
    logic ok;
    ok = 1'b0;
    case (code)
      `LPC_SIZE_1, `LPC_SIZE_2, `LPC_SIZE_4: ok = 1'b1;
      `LPC_SIZE_16, `LPC_SIZE_128: ok = !is_write;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : size_valid

  function automatic logic [7:0] nibble_last(input logic [3:0] code);
    logic [8:0] total;
    total = `LPC_NIBBLES_ONE_BYTE << code[2:0];
    return 8'(total - `LPC_NIBBLE_ONE);
  endfunction : nibble_last

  function automatic logic [20:0] align_mask(input logic [3:0] code);
    logic [20:0] m;
    m = ~21'h000000;
    m = m << code[2:0];
    return m;
  endfunction : align_mask

endpackage : lpc_fw_pkg

/* File: rtl/level_sync.sv */
// two-flop synchroniser for slow levels and reset release.
// assumes: d is quasi-static relative to clk.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // level
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [1:0][W-1:0] stage;
  logic [1:0][W-1:0] next_stage;

  always_comb begin
    next_stage[0] = d;
    next_stage[1] = stage[0];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign q = stage[1];

endmodule : level_sync

`default_nettype wire

/* File: rtl/toggle_pulse.sv */
// turns a toggle from another clock domain into a one-cycle pulse.
// assumes: the source toggles no faster than once per four dst cycles.
`timescale 1ns/1ps
`default_nettype none

module toggle_pulse (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // event
  input wire logic toggle,
  output logic pulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic seen;
    logic pulse;
  } tp_state_t;

  tp_state_t s;
  tp_state_t next_s;

  always_comb begin
    next_s.meta = toggle;
    next_s.sync = s.meta;
    next_s.seen = s.sync;
    next_s.pulse = s.sync ^ s.seen;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.pulse;

endmodule : toggle_pulse

`default_nettype wire

/* File: rtl/lpc_fw_target.sv */
// firmware memory read target: decodes cycles on the link clock, serves
// read bursts from a byte array port, and reports write cycles, command
// pairs and standby in the system clock domain.
// assumes: array_data shows the byte at array_addr one link clock after
// array_addr changes; busy comes from the program engine on clk_sys.
`timescale 1ns/1ps
`default_nettype none

`include "lpc_fw_map.svh"

// Notes on behaviour
// - standby when frame high and engine idle
// - start nibble is last one with frame low
// - 1101 read, 1110 write, others ignored
// - second clock identity nibble must match strap
// - seven address nibbles, most significant first
// - read sizes 1,2,4,16,128 bytes only
// - writes limited to 1, 2 or 4 bytes
// - host turnaround clock eleven, device drives twelve
// - ready sync 0000 on clock thirteen
// - data nibbles low nibble, low byte first
// - drive 1111 once after data, then release
// - fields sampled on rising link clock edge
// - two write cycles form one command
// - bad size returns idle with no response
// - frame low aborts current cycle only
// - unaligned burst starts at page base
module lpc_fw_target (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link pins
  input wire logic lclk,
  input wire logic lframe_n,
  input wire logic [3:0] lad_in,
  output lpc_fw_pkg::lad_drive_t lad,
  // straps and mode detect
  input wire logic [3:0] identity_strap,
  input wire logic auto_increment_mode,
  // byte array read port, link clock
  output logic [20:0] array_addr,
  output logic array_space,
  input wire logic [7:0] array_data,
  // program engine side, system clock
  input wire logic busy,
  output logic standby,
  output logic write_cycle,
  output logic cmd_pending,
  output logic cmd_start,
  output logic [27:0] cmd_addr
);
  import lpc_fw_pkg::*;

  // ---------------------------------------------------------------
  // crossings
  // ---------------------------------------------------------------
  logic link_reset_n;
  logic [4:0] pins_sync;
  logic frame_idle_sys;
  logic write_pulse;
  link_state_t s;
  link_state_t next_s;
  sys_state_t q;
  sys_state_t next_q;

  level_sync #(.W(1)) u_link_reset (
    .clk(lclk),
    .reset_n(reset_n),
    .d(1'b1),
    .q(link_reset_n)
  );

  level_sync #(.W(5)) u_pin_sync (
    .clk(lclk),
    .reset_n(link_reset_n),
    .d({auto_increment_mode, identity_strap}),
    .q(pins_sync)
  );

  level_sync #(.W(1)) u_idle_sync (
    .clk(clk_sys),
    .reset_n(reset_n),
    .d(s.frame_idle),
    .q(frame_idle_sys)
  );

  toggle_pulse u_write_event (
    .clk(clk_sys),
    .reset_n(reset_n),
    .toggle(s.write_toggle),
    .pulse(write_pulse)
  );

  // ---------------------------------------------------------------
  // link clock: cycle decode and read burst
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (!lframe_n) begin
      next_s.phase = PH_START;
      next_s.start_code = lad_in;
      next_s.lad.enable = `LPC_LAD_RELEASE;
      next_s.frame_idle = 1'b0;
    end else begin
      case (s.phase)
        PH_IDLE: begin
          next_s.frame_idle = 1'b1;
          next_s.lad.enable = `LPC_LAD_RELEASE;
        end
        PH_START: begin
          next_s.phase = PH_IDLE;
          if ((s.start_code == `LPC_START_READ ||
               s.start_code == `LPC_START_WRITE) &&
              lad_in == pins_sync[3:0] &&
              !pins_sync[4]) begin
            next_s.phase = PH_ADDR;
            next_s.write_dir = (s.start_code == `LPC_START_WRITE);
            next_s.addr_left = `LPC_ADDR_NIBBLES;
          end
        end
        PH_ADDR: begin
          next_s.addr = {s.addr[`LPC_ADDR_KEEP_MSB:0], lad_in};
          next_s.addr_left = s.addr_left - `LPC_ADDR_LAST;
          if (s.addr_left == `LPC_ADDR_LAST) begin
            next_s.phase = PH_SIZE;
          end
        end
        PH_SIZE: begin
          next_s.size_code = lad_in;
          if (!size_valid(lad_in, s.write_dir)) begin
            next_s.phase = PH_IDLE;
          end else if (s.write_dir) begin
            next_s.phase = PH_IDLE;
            next_s.write_addr = s.addr;
            next_s.write_toggle = !s.write_toggle;
          end else begin
            next_s.phase = PH_TAR0;
            next_s.byte_addr = s.addr[`LPC_DECODE_MSB:0] &
                               align_mask(lad_in);
            next_s.flash_space = s.addr[`LPC_SPACE_BIT];
            next_s.nib_last = nibble_last(lad_in);
            next_s.nib_count = '0;
          end
        end
        PH_TAR0: begin
          next_s.phase = PH_TAR1;
          next_s.lad.value = `LPC_TAR_NIBBLE;
          next_s.lad.enable = `LPC_LAD_DRIVE;
        end
        PH_TAR1: begin
          next_s.phase = PH_SYNC;
          next_s.lad.value = `LPC_SYNC_READY;
        end
        PH_SYNC: begin
          next_s.phase = PH_DATA;
          next_s.lad.value = array_data[3:0];
          next_s.hold_hi = array_data[7:4];
          next_s.byte_addr = s.byte_addr + `LPC_ADDR_STEP;
          next_s.nib_count = '0;
        end
        PH_DATA: begin
          if (s.nib_count == s.nib_last) begin
            next_s.phase = PH_TAR_END;
            next_s.lad.value = `LPC_TAR_NIBBLE;
          end else begin
            next_s.nib_count = s.nib_count + `LPC_COUNT_STEP;
            if (!s.nib_count[0]) begin
              next_s.lad.value = s.hold_hi;
            end else begin
              next_s.lad.value = array_data[3:0];
              next_s.hold_hi = array_data[7:4];
              next_s.byte_addr = s.byte_addr + `LPC_ADDR_STEP;
            end
          end
        end
        PH_TAR_END: begin
          next_s.phase = PH_IDLE;
          next_s.lad.enable = `LPC_LAD_RELEASE;
          next_s.frame_idle = 1'b1;
        end
        default: begin
          next_s.phase = PH_IDLE;
          next_s.lad.enable = `LPC_LAD_RELEASE;
        end
      endcase
    end
  end

  always_ff @(posedge lclk or negedge link_reset_n) begin
    if (!link_reset_n) begin
      s <= '{phase: PH_IDLE, frame_idle: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign lad = s.lad;
  assign array_addr = s.byte_addr;
  assign array_space = s.flash_space;

  // ---------------------------------------------------------------
  // system clock: standby and command pairing
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.standby = frame_idle_sys && !busy;
    next_q.write_cycle = write_pulse;
    next_q.cmd_start = 1'b0;
    if (write_pulse) begin
      next_q.cmd_addr = s.write_addr;
      if (!q.cmd_pending) begin
        next_q.cmd_pending = 1'b1;
      end else begin
        next_q.cmd_pending = 1'b0;
        next_q.cmd_start = !busy;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign standby = q.standby;
  assign write_cycle = q.write_cycle;
  assign cmd_pending = q.cmd_pending;
  assign cmd_start = q.cmd_start;
  assign cmd_addr = q.cmd_addr;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  start_decode_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n)
    s.phase == PH_START && lframe_n &&
    s.start_code != `LPC_START_READ && s.start_code != `LPC_START_WRITE
    |=> s.phase == PH_IDLE && s.lad.enable == `LPC_LAD_RELEASE)
    else $error("unknown start code was accepted");

  id_match_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n)
    s.phase == PH_START && lframe_n && lad_in != pins_sync[3:0]
    |=> s.phase == PH_IDLE)
    else $error("cycle taken with a foreign identity nibble");

  addr_field_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n || !lframe_n)
    s.phase == PH_START && next_s.phase == PH_ADDR
    |=> s.phase == PH_ADDR [*7] ##1 s.phase == PH_SIZE)
    else $error("address field is not seven nibbles");

  size_reject_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n)
    s.phase == PH_SIZE && lframe_n && !size_valid(lad_in, s.write_dir)
    |=> s.phase == PH_IDLE ##1 s.lad.enable == `LPC_LAD_RELEASE)
    else $error("unsupported size did not drop the cycle");

  read_preamble_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n || !lframe_n)
    s.phase == PH_SIZE && !s.write_dir && size_valid(lad_in, 1'b0)
    |=> s.lad.enable == `LPC_LAD_RELEASE
    ##1 s.lad.enable == `LPC_LAD_DRIVE && s.lad.value == `LPC_TAR_NIBBLE)
    else $error("device turnaround not on clock twelve");

  ready_sync_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n)
    s.phase == PH_TAR1 && lframe_n
    |=> s.lad.value == `LPC_SYNC_READY && s.lad.enable == `LPC_LAD_DRIVE)
    else $error("ready sync not driven after turnaround");

  burst_end_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n || !lframe_n)
    s.phase == PH_DATA && s.nib_count == s.nib_last
    |=> s.lad.value == `LPC_TAR_NIBBLE && s.lad.enable == `LPC_LAD_DRIVE
    ##1 s.lad.enable == `LPC_LAD_RELEASE)
    else $error("burst end turnaround wrong");

  burst_length_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n)
    s.phase == PH_DATA |-> s.nib_last == nibble_last(s.size_code) &&
    s.nib_count <= s.nib_last)
    else $error("burst nibble count out of range");

  page_align_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n)
    s.phase == PH_TAR0 |-> (s.byte_addr & ~align_mask(s.size_code)) == '0)
    else $error("burst start not aligned to its page");

  abort_cycle_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n)
    !lframe_n |=> s.phase == PH_START && s.lad.enable == `LPC_LAD_RELEASE)
    else $error("frame low did not end the cycle");

  lad_release_a: assert property (
    @(posedge lclk) disable iff (!link_reset_n)
    s.lad.enable != `LPC_LAD_RELEASE
    |-> s.phase inside {PH_TAR1, PH_SYNC, PH_DATA, PH_TAR_END})
    else $error("lad driven outside its own clocks");

  standby_entry_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    frame_idle_sys && !busy |=> standby)
    else $error("standby missing while idle");

  cmd_pair_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    write_pulse && cmd_pending && !busy |=> cmd_start && !cmd_pending)
    else $error("second write did not start the command");

endmodule : lpc_fw_target

`default_nettype wire

/* File: bench/lpc_host_model.sv */
// host side of the link: frames cycles and records the device drive.
// assumes: the bench calls run; lad is the target's registered drive.
`timescale 1ns/1ps
`default_nettype none

module lpc_host_model (
  // link
  input wire logic lclk,
  input wire lpc_fw_pkg::lad_drive_t lad,
  output logic lframe_n,
  output logic [3:0] lad_in
);
  import lpc_fw_pkg::*;
  logic [3:0] hv = 4'hF;
  logic hen = 1'b0;
  logic [3:0] last = 4'h0;
  logic [7:0] obs [$];
  initial lframe_n = 1'b1;
  // released wire shows the inverse of its last level
  assign lad_in = (lad.enable === 4'hF) ? lad.value : hen ? hv : ~last;
  always @(posedge lclk) last <= lad_in;
  // ---------------------------------------------------------------
  // one framed cycle, then n records of the device drive
  // ---------------------------------------------------------------
  task automatic run(input logic [3:0] st, id, input logic [27:0] a,
                     input logic [3:0] sz, input int n, ab);
    obs.delete();
    @(posedge lclk);
    lframe_n <= 1'b0;
    hv <= 4'hD;
    hen <= 1'b1;
    @(posedge lclk);
    hv <= st;
    @(posedge lclk);
    lframe_n <= 1'b1;
    hv <= id;
    for (int i = 6; i >= 0; i--) begin
      @(posedge lclk);
      hv <= a[4*i +: 4];
    end
    @(posedge lclk);
    hv <= sz;
    @(posedge lclk);
    hv <= 4'hF;
    @(posedge lclk);
    hen <= 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i > 0) @(posedge lclk);
      #1;
      obs.push_back({lad.enable, lad.value});
      if (i == ab) begin
        lframe_n <= 1'b0;
        hen <= 1'b1;
        hv <= 4'hF;
      end
      if (i == ab + 1) begin
        lframe_n <= 1'b1;
        hen <= 1'b0;
      end
    end
    @(posedge lclk);
    lframe_n <= 1'b1;
    hen <= 1'b0;
  endtask : run
endmodule : lpc_host_model

`default_nettype wire

/* File: bench/test_lpc_fw_target.sv */
// self-checking bench of the firmware memory read target.
// assumes: the host model frames cycles; the bench plays the byte array.
`timescale 1ns/1ps
`default_nettype none

module test_lpc_fw_target;
  import lpc_fw_pkg::*;
  // ---------------------------------------------------------------
  // clocks, pins and counters
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic lclk = 1'b0;
  logic reset_n = 1'b0;
  logic lframe_n;
  logic [3:0] lad_in;
  lad_drive_t lad;
  logic [3:0] identity_strap = 4'h0;
  logic auto_increment_mode = 1'b0;
  logic [20:0] array_addr;
  logic array_space;
  logic [7:0] array_data = 8'h00;
  logic busy = 1'b0;
  logic standby, write_cycle, cmd_pending, cmd_start;
  logic [27:0] cmd_addr;
  logic [27:0] a;
  logic [15:0] lfsr = 16'h0009;
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7};
  logic [11:0] bad [10] = '{12'hD03, 12'hD05, 12'hD06, 12'hD08, 12'hD0F,
                            12'hC00, 12'hF00, 12'hD10, 12'hE04, 12'hE07};
  int err_count = 0;
  int compares = 0;
  int wc_seen = 0;
  int cs_seen = 0;
  int w;
  always #5 clk_sys = ~clk_sys;
  always #40 lclk = ~lclk;
  always @(posedge lclk) array_data <= mem_byte(array_addr);
  always @(posedge clk_sys) begin
    if (write_cycle === 1'b1) wc_seen++;
    if (cmd_start === 1'b1) cs_seen++;
  end
  lpc_fw_target i_lpc_fw_target (.clk_sys(clk_sys), .reset_n(reset_n),
    .lclk(lclk), .lframe_n(lframe_n), .lad_in(lad_in), .lad(lad),
    .identity_strap(identity_strap),
    .auto_increment_mode(auto_increment_mode), .array_addr(array_addr),
    .array_space(array_space), .array_data(array_data), .busy(busy),
    .standby(standby), .write_cycle(write_cycle),
    .cmd_pending(cmd_pending), .cmd_start(cmd_start), .cmd_addr(cmd_addr));
  lpc_host_model i_lpc_host_model (.lclk(lclk), .lad(lad),
    .lframe_n(lframe_n), .lad_in(lad_in));
  // ---------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  function automatic logic [7:0] mem_byte(input logic [20:0] x);
    return x[7:0] ^ x[15:8] ^ 8'hA5;
  endfunction : mem_byte
  function automatic logic [7:0] exp_lad(input logic [27:0] x,
                                         input logic [3:0] sz, input int i);
    logic [20:0] base;
    logic [7:0] b;
    int nn;
    nn = 2 << sz;
    base = x[20:0] & (~21'h000000 << sz);
    b = mem_byte(base + 21'((i - 2) / 2));
    if (i == 0) return 8'hFF;
    if (i == 1) return 8'hF0;
    if (i < nn + 2) return {4'hF, (i % 2 == 0) ? b[3:0] : b[7:4]};
    if (i == nn + 2) return 8'hFF;
    return 8'h00;
  endfunction : exp_lad
  task automatic chk(input logic [27:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input logic [3:0] st, id, input logic [27:0] x,
                     input logic [3:0] sz, input int n, ab, input logic ok);
    logic [7:0] e;
    logic [7:0] g;
    i_lpc_host_model.run(st, id, x, sz, n, ab);
    for (int i = 0; i < n; i++) begin
      e = (ok && (ab < 0 || i <= ab)) ? exp_lad(x, sz, i) : 8'h00;
      g = i_lpc_host_model.obs[i];
      chk({20'h0, (e == 8'h00) ? {g[7:4], 4'h0} : g}, {20'h0, e},
          "lad");
    end
  endtask : cyc
  task automatic rnd_addr();
    lfsr = lfsr_next(lfsr);
    a[15:0] = lfsr;
    lfsr = lfsr_next(lfsr);
    a[27:16] = lfsr[11:0];
  endtask : rnd_addr
  task automatic done(input string name);
    $display("test %s done, errors %0d", name, err_count);
  endtask : done
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #500000;
    err_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    identity_strap = lfsr[3:0];
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge lclk);
    for (int k = 0; k < 5; k++) begin
      rnd_addr();
      if (k == 4) a = 28'h7FFFFFF;
      cyc(4'hD, identity_strap, a, codes[k], (2 << codes[k]) + 4, -1, 1'b1);
      chk({27'h0, array_space}, {27'h0, a[22]}, "space");
    end
    done("read sizes");
    w = wc_seen;
    for (int k = 0; k < 10; k++) begin
      rnd_addr();
      cyc(bad[k][11:8], identity_strap ^ bad[k][7:4], a, bad[k][3:0],
          12, -1, 1'b0);
    end
    repeat (10) @(posedge clk_sys);
    chk(28'(wc_seen), 28'(w), "refused writes");
    done("refusals");
    @(posedge clk_sys);
    auto_increment_mode <= 1'b1;
    repeat (4) @(posedge lclk);
    cyc(4'hD, identity_strap, a, 4'h0, 8, -1, 1'b0);
    @(posedge clk_sys);
    auto_increment_mode <= 1'b0;
    repeat (4) @(posedge lclk);
    done("mode");
    rnd_addr();
    cyc(4'hE, identity_strap, a, 4'h0, 6, -1, 1'b0);
    repeat (10) @(posedge clk_sys);
    chk(28'(wc_seen), 28'(w + 1), "write pulse");
    chk({27'h0, cmd_pending}, 28'h1, "pending");
    chk(cmd_addr, a, "cmd addr");
    cyc(4'hD, identity_strap, a, 4'h4, 36, 5, 1'b1);
    chk({27'h0, cmd_pending}, 28'h1, "pending kept");
    rnd_addr();
    cyc(4'hE, identity_strap, a, 4'h2, 6, -1, 1'b0);
    repeat (10) @(posedge clk_sys);
    chk(28'(cs_seen), 28'h1, "cmd start");
    chk({27'h0, cmd_pending}, 28'h0, "pair closed");
    chk(cmd_addr, a, "cmd addr");
    done("writes and abort");
    @(posedge clk_sys);
    busy <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk({27'h0, standby}, 28'h0, "standby busy");
    busy <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk({27'h0, standby}, 28'h1, "standby idle");
    done("standby");
    stop_test();
  end
endmodule : test_lpc_fw_target

`default_nettype wire
